// ---- core/wdh_watchdog_halt.sv ----
// Watchdog timer with halt control, wake-up sequencing and start-up delay.
// Assumes a free-running clk; oscillator pins arrive asynchronously and are
// sampled here, the interrupt summary comes from logic on the same clock.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

// Behaviour
// - Watchdog clock is RC oscillator, 32768 Hz clock or system clock over four.
// - With the watchdog disabled, every watchdog operation does nothing.
// - The 32768 Hz source is legal only in internal RC plus slow crystal mode.
// - The watchdog source first passes a fixed divide-by-256 stage.
// - Select bits 2..0 add a prescale ratio of two to the field value.
// - Select bit 3 and bits 7..4 are plain software storage.
// - Overflow while running resets the chip and sets the expiry flag.
// - Overflow in halt gives a warm reset of program counter and stack pointer.
// - Low reset pin or clear instruction clears counter and prescaler.
// - Single mode clears on one instruction; dual mode needs both instructions.
// - Instruction-clocked watchdog stops counting in halt.
// - Halt stops the system clock but keeps RC oscillator and state.
// - Entering halt clears counter and prescaler; RC source counts on.
// - Halt sets the halt flag and clears the expiry flag.
// - Power-up or single clear clears halt flag; timeout sets expiry flag.
// - Halt ends on reset pin, interrupt, port A falling edge or overflow.
// - Port A wake bits are build options; port wake resumes at next instruction.
// - Interrupt wake resumes if disabled or stack full, otherwise vectors.
// - An interrupt already pending at halt entry cannot wake the device.
// - Every wake-up waits 1024 system clocks before resuming.
// - Interrupt service starts a cycle after the delay; resume starts at once.
// - In external RC mode the system clock over four drives the clock pin.
module wdh_watchdog_halt #(
    parameter bit              WDT_EN      = 1'b1,
    parameter wdh_pkg::wdh_src_t CLK_SRC   = wdh_pkg::SRC_RC,
    parameter bit              RC_RTC_MODE = 1'b0,
    parameter bit              EXT_RC_MODE = 1'b0,
    parameter bit              DUAL_CLEAR  = 1'b0,
    parameter logic [7:0]      PA_WAKE     = 8'hff,
    parameter int              SYS_DIV     = wdh_pkg::SYS_DIV
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire wdh_pkg::wdh_bus_t bus,
    output logic [7:0]             rdata_r,
    input  wire logic              wdt_osc_pin,
    input  wire logic              rtc_pin,
    input  wire logic              external_init_pin_n,
    input  wire logic [7:0]        port_a_pin,
    input  wire wdh_pkg::wdh_irq_t irq,
    output logic                   sys_tick_r,
    output logic                   halted_r,
    output logic                   chip_reset_r,
    output logic                   warm_reset_r,
    output logic                   resume_r,
    output logic                   irq_ack_r,
    output logic                   clock_pin_out_r
);

    // ----------------------------------------------------------------
    // Build-time checks
    // ----------------------------------------------------------------
    if (SYS_DIV < 1) begin : g_bad_div
        $error("SYS_DIV must be at least one");
    end
    if (CLK_SRC == wdh_pkg::SRC_RTC && !RC_RTC_MODE) begin : g_bad_rtc
        $error("Slow crystal source needs internal RC plus crystal mode");
    end

    localparam int DW = $clog2(SYS_DIV + 1);

    function automatic logic [6:0] ratio_m1(input logic [2:0] sel);
        ratio_m1 = 7'((8'h01 << sel) - 8'h01);
    endfunction

    function automatic logic rise(input logic now, input logic was);
        rise = now & ~was;
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Order: port A, reset pin, slow crystal, RC oscillator.
    logic [10:0] sync1_r;
    logic [10:0] sync2_r;
    logic [10:0] prev_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= 11'h7fc;
            sync2_r <= 11'h7fc;
            prev_r  <= 11'h7fc;
        end else begin
            sync1_r <= {port_a_pin, external_init_pin_n, rtc_pin, wdt_osc_pin};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    logic       ext_low;
    logic       port_fall;
    logic       rc_tick;
    logic       rtc_tick;

    assign ext_low   = ~sync2_r[2];
    assign port_fall = |(prev_r[10:3] & ~sync2_r[10:3] & PA_WAKE);
    assign rc_tick   = rise(sync2_r[0], prev_r[0]);
    // The slow crystal tick is never gated by halt, so it counts on.
    assign rtc_tick  = rise(sync2_r[1], prev_r[1]) & RC_RTC_MODE;

    // ----------------------------------------------------------------
    // System clock enable and instruction clock
    // ----------------------------------------------------------------
    wdh_pkg::wdh_state_t state_r;
    wdh_pkg::wdh_state_t state_nxt;
    logic [DW-1:0]       sys_cnt_r;
    logic [1:0]          phase_r;
    logic                running;
    logic                sys_tick_nxt;
    logic                instr_tick;

    assign running      = (state_r != wdh_pkg::ST_HALT);
    assign sys_tick_nxt = running && (sys_cnt_r == DW'(SYS_DIV - 1));
    assign instr_tick   = sys_tick_r && (phase_r == 2'(wdh_pkg::INSTR_DIV - 1));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sys_cnt_r  <= '0;
            sys_tick_r <= 1'b0;
        end else begin
            sys_tick_r <= sys_tick_nxt;
            if (!running || sys_tick_nxt) begin
                sys_cnt_r <= '0;
            end else begin
                sys_cnt_r <= sys_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_r         <= 2'h0;
            clock_pin_out_r <= 1'b0;
        end else if (sys_tick_r) begin
            phase_r         <= phase_r + 2'h1;
            clock_pin_out_r <= EXT_RC_MODE & phase_r[1];
        end
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    logic [7:0] sel_r;
    logic       halt_flag_r;
    logic       exp_flag_r;
    logic       first_seen_r;
    logic       second_seen_r;
    logic [7:0] base_r;
    logic [6:0] pre_r;
    logic       cmd_wr;
    logic       clr_single;
    logic       clr_first;
    logic       clr_second;
    logic       eff_clear;
    logic       halt_go;
    logic       enter_chip_rst;

    assign cmd_wr     = bus.wr && (bus.addr == wdh_pkg::ADDR_CMD);
    assign clr_single = WDT_EN && !DUAL_CLEAR && cmd_wr && bus.wdata[wdh_pkg::CMD_CLR_SINGLE];
    assign clr_first  = WDT_EN && DUAL_CLEAR && cmd_wr && bus.wdata[wdh_pkg::CMD_CLR_FIRST];
    assign clr_second = WDT_EN && DUAL_CLEAR && cmd_wr && bus.wdata[wdh_pkg::CMD_CLR_SECOND];
    assign eff_clear  = clr_single ||
                        ((clr_first || first_seen_r) && (clr_second || second_seen_r));
    assign halt_go    = (state_r == wdh_pkg::ST_RUN) && cmd_wr &&
                        bus.wdata[wdh_pkg::CMD_HALT] && !ext_low;

    // The pair of clear instructions may come in either order, but a clear
    // only counts once both halves have been seen since the last clear.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            first_seen_r  <= 1'b0;
            second_seen_r <= 1'b0;
        end else if (eff_clear || ext_low) begin
            first_seen_r  <= 1'b0;
            second_seen_r <= 1'b0;
        end else begin
            first_seen_r  <= first_seen_r | clr_first;
            second_seen_r <= second_seen_r | clr_second;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_r <= wdh_pkg::SEL_RST;
        end else if (enter_chip_rst) begin
            sel_r <= wdh_pkg::SEL_RST;
        end else if (bus.wr && bus.addr == wdh_pkg::ADDR_SEL) begin
            sel_r <= bus.wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                wdh_pkg::ADDR_SEL:  rdata_r <= sel_r;
                wdh_pkg::ADDR_STAT: rdata_r <= (8'(exp_flag_r) << wdh_pkg::STAT_EXP_BIT) |
                                               (8'(halt_flag_r) << wdh_pkg::STAT_HALT_BIT);
                wdh_pkg::ADDR_CNT:  rdata_r <= base_r;
                default:            rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Watchdog counter and prescaler
    // ----------------------------------------------------------------
    logic wdt_tick;
    logic ovf;

    always_comb begin
        case (CLK_SRC)
            wdh_pkg::SRC_RC:    wdt_tick = rc_tick;
            wdh_pkg::SRC_RTC:   wdt_tick = rtc_tick;
            wdh_pkg::SRC_INSTR: wdt_tick = instr_tick;
            default:            wdt_tick = 1'b0;
        endcase
        wdt_tick = wdt_tick & WDT_EN;
    end

    assign ovf = wdt_tick && (base_r == 8'(wdh_pkg::BASE_DIV - 1)) &&
                 (pre_r == ratio_m1(sel_r[2:0])) && !chip_reset_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            base_r <= 8'h00;
            pre_r  <= 7'h00;
        end else if (ext_low || eff_clear || halt_go || chip_reset_r || ovf) begin
            base_r <= 8'h00;
            pre_r  <= 7'h00;
        end else if (wdt_tick) begin
            base_r <= base_r + 8'h01;
            if (base_r == 8'(wdh_pkg::BASE_DIV - 1)) begin
                pre_r <= pre_r + 7'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    // Hardware sets win over software clears in the same cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            exp_flag_r <= 1'b0;
        end else if (ovf) begin
            exp_flag_r <= 1'b1;
        end else if (halt_go || eff_clear) begin
            exp_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            halt_flag_r <= 1'b0;
        end else if (halt_go) begin
            halt_flag_r <= 1'b1;
        end else if (eff_clear) begin
            halt_flag_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Halt, wake-up and start-up sequencing
    // ----------------------------------------------------------------
    wdh_pkg::wdh_cause_t cause_r;
    wdh_pkg::wdh_cause_t cause_nxt;
    logic [9:0]          wait_cnt_r;
    logic                irq_armed_r;
    logic                wait_done;

    assign wait_done = (state_r == wdh_pkg::ST_WAIT) && sys_tick_r &&
                       (wait_cnt_r == 10'(wdh_pkg::STARTUP_CLKS - 1)) && !ext_low;
    assign enter_chip_rst = (state_nxt == wdh_pkg::ST_WAIT) &&
                            (cause_nxt == wdh_pkg::CAUSE_EXT ||
                             cause_nxt == wdh_pkg::CAUSE_WDTN);

    always_comb begin
        state_nxt = state_r;
        cause_nxt = cause_r;
        case (state_r)
            wdh_pkg::ST_RUN: begin
                if (ext_low) begin
                    state_nxt = wdh_pkg::ST_WAIT;
                    cause_nxt = wdh_pkg::CAUSE_EXT;
                end else if (ovf) begin
                    state_nxt = wdh_pkg::ST_WAIT;
                    cause_nxt = wdh_pkg::CAUSE_WDTN;
                end else if (halt_go) begin
                    state_nxt = wdh_pkg::ST_HALT;
                end
            end
            wdh_pkg::ST_HALT: begin
                state_nxt = wdh_pkg::ST_WAIT;
                if (ext_low) begin
                    cause_nxt = wdh_pkg::CAUSE_EXT;
                end else if (ovf) begin
                    cause_nxt = wdh_pkg::CAUSE_WARM;
                end else if (port_fall) begin
                    cause_nxt = wdh_pkg::CAUSE_PORT;
                end else if (irq.req && irq_armed_r) begin
                    cause_nxt = wdh_pkg::CAUSE_IRQ;
                end else begin
                    state_nxt = wdh_pkg::ST_HALT;
                end
            end
            wdh_pkg::ST_WAIT: begin
                if (ext_low) begin
                    cause_nxt = wdh_pkg::CAUSE_EXT;
                end else if (wait_done) begin
                    state_nxt = wdh_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = wdh_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r  <= wdh_pkg::ST_RUN;
            cause_r  <= wdh_pkg::CAUSE_EXT;
            halted_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cause_r  <= cause_nxt;
            halted_r <= (state_nxt == wdh_pkg::ST_HALT);
        end
    end

    // A request already pending at halt entry is not a fresh event.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_armed_r <= 1'b0;
        end else if (halt_go) begin
            irq_armed_r <= ~irq.req;
        end
    end

    // The reset pin held low keeps the start-up count at zero, so the
    // delay always runs its full length after the pin is released.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_cnt_r <= 10'h000;
        end else if (state_r != wdh_pkg::ST_WAIT || ext_low) begin
            wait_cnt_r <= 10'h000;
        end else if (sys_tick_r) begin
            wait_cnt_r <= wait_cnt_r + 10'h001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chip_reset_r <= 1'b1;
        end else begin
            chip_reset_r <= (state_nxt == wdh_pkg::ST_WAIT) &&
                            (cause_nxt == wdh_pkg::CAUSE_EXT ||
                             cause_nxt == wdh_pkg::CAUSE_WDTN);
        end
    end

    logic ack_pend_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            warm_reset_r <= 1'b0;
            resume_r     <= 1'b0;
            ack_pend_r   <= 1'b0;
            irq_ack_r    <= 1'b0;
        end else begin
            warm_reset_r <= wait_done && (cause_r == wdh_pkg::CAUSE_WARM);
            resume_r     <= wait_done && (cause_r == wdh_pkg::CAUSE_PORT ||
                            (cause_r == wdh_pkg::CAUSE_IRQ &&
                             (!irq.enabled || irq.stack_full)));
            ack_pend_r   <= wait_done && cause_r == wdh_pkg::CAUSE_IRQ &&
                            irq.enabled && !irq.stack_full;
            irq_ack_r    <= ack_pend_r;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_wait_end;
        state_r == wdh_pkg::ST_WAIT && wait_done;
    endsequence

    sequence s_halt_entry;
        halt_go && !ovf;
    endsequence

    a_ovf_sets_expiry: assert property (@(posedge clk) disable iff (!nrst)
        ovf |=> exp_flag_r)
        else $error("Overflow did not set the expiry flag");

    a_halt_flag_pair: assert property (@(posedge clk) disable iff (!nrst)
        s_halt_entry |=> halt_flag_r && !exp_flag_r && halted_r)
        else $error("Halt entry flags wrong");

    a_halt_clears_wdt: assert property (@(posedge clk) disable iff (!nrst)
        halt_go |=> base_r == 8'h00 && pre_r == 7'h00)
        else $error("Halt did not clear the watchdog");

    a_clear_wdt: assert property (@(posedge clk) disable iff (!nrst)
        (eff_clear || ext_low) |=> base_r == 8'h00 && pre_r == 7'h00)
        else $error("Clear did not reach the watchdog");

    a_halt_no_clock: assert property (@(posedge clk) disable iff (!nrst)
        state_r == wdh_pkg::ST_HALT ##1 state_r == wdh_pkg::ST_HALT |-> !sys_tick_r)
        else $error("System clock ran during halt");

    a_startup_done: assert property (@(posedge clk) disable iff (!nrst)
        s_wait_end |=> state_r == wdh_pkg::ST_RUN && !chip_reset_r)
        else $error("Start-up delay did not end in run");

    a_stale_irq: assert property (@(posedge clk) disable iff (!nrst)
        state_r == wdh_pkg::ST_HALT && !irq_armed_r && !ext_low && !ovf && !port_fall
        |=> state_r == wdh_pkg::ST_HALT)
        else $error("Stale interrupt woke the device");

    a_irq_ack_late: assert property (@(posedge clk) disable iff (!nrst)
        s_wait_end ##0 (cause_r == wdh_pkg::CAUSE_IRQ && irq.enabled && !irq.stack_full)
        |=> !irq_ack_r ##1 irq_ack_r)
        else $error("Interrupt acknowledge not one cycle after delay");

    a_warm_pulse: assert property (@(posedge clk) disable iff (!nrst)
        warm_reset_r |-> !chip_reset_r ##1 !warm_reset_r)
        else $error("Warm reset not a single clean pulse");

    a_ext_reset: assert property (@(posedge clk) disable iff (!nrst)
        ext_low |=> chip_reset_r && state_r == wdh_pkg::ST_WAIT)
        else $error("Reset pin did not start chip reset");

endmodule

// ---- shared/wdh_pkg.sv ----
// Constants, types and register map of the watchdog and halt wake-up block.
// Assumes a single 200 MHz fabric clock that never stops, even in halt.
package wdh_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int           ADDR_W         = 4;
    localparam logic [3:0]   ADDR_SEL       = 4'h0;
    localparam logic [3:0]   ADDR_STAT      = 4'h1;
    localparam logic [3:0]   ADDR_CMD       = 4'h2;
    localparam logic [3:0]   ADDR_CNT       = 4'h3;
    localparam logic [7:0]   SEL_RST        = 8'h07;
    localparam int           SEL_RATIO_LSB  = 0;
    localparam int           STAT_HALT_BIT  = 4;
    localparam int           STAT_EXP_BIT   = 5;
    localparam int           CMD_CLR_SINGLE = 0;
    localparam int           CMD_CLR_FIRST  = 1;
    localparam int           CMD_CLR_SECOND = 2;
    localparam int           CMD_HALT       = 3;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int           CLK_PERIOD_PS  = 5000;
    localparam int           SYS_PERIOD_PS  = 125000;
    localparam int           SYS_DIV        = SYS_PERIOD_PS / CLK_PERIOD_PS;
    localparam int           INSTR_DIV      = 4;
    localparam int           BASE_DIV       = 256;
    localparam int           STARTUP_CLKS   = 1024;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_RC    = 2'h0,
        SRC_RTC   = 2'h1,
        SRC_INSTR = 2'h2
    } wdh_src_t;

    typedef enum logic [2:0] {
        ST_RUN  = 3'h1,
        ST_HALT = 3'h2,
        ST_WAIT = 3'h4
    } wdh_state_t;

    typedef enum logic [4:0] {
        CAUSE_EXT  = 5'h01,
        CAUSE_WDTN = 5'h02,
        CAUSE_WARM = 5'h04,
        CAUSE_PORT = 5'h08,
        CAUSE_IRQ  = 5'h10
    } wdh_cause_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } wdh_bus_t;

    typedef struct packed {
        logic req;
        logic enabled;
        logic stack_full;
    } wdh_irq_t;

endpackage

// ---- test/wdh_watchdog_halt_bench.sv ----
// Self-checking bench for the watchdog and halt wake-up block.
// Assumes the block's own assertions; this file drives ports and judges results.
`timescale 1ns/1ps
module wdh_watchdog_halt_bench;
    logic              clk;
    logic              nrst;
    wdh_pkg::wdh_bus_t bus;
    wdh_pkg::wdh_irq_t irq;
    logic [7:0]        rdata_r;
    logic [7:0]        port_a_pin;
    logic              wdt_osc_pin;
    logic              rtc_pin;
    logic              ext_n;
    logic              sys_tick_r;
    logic              halted_r;
    logic              chip_reset_r;
    logic              warm_reset_r;
    logic              resume_r;
    logic              irq_ack_r;
    logic              clock_pin_out_r;
    logic [7:0]        rd;
    logic [7:0]        rdata2;
    logic              clk_out2;
    logic [2:0]        kind;
    int                nt;
    int                err_count;
    int                num_checks;

    wdh_watchdog_halt #(.SYS_DIV(2)) dut (.clk(clk), .nrst(nrst), .bus(bus), .rdata_r(rdata_r),
        .wdt_osc_pin(wdt_osc_pin), .rtc_pin(rtc_pin), .external_init_pin_n(ext_n),
        .port_a_pin(port_a_pin), .irq(irq), .sys_tick_r(sys_tick_r), .halted_r(halted_r),
        .chip_reset_r(chip_reset_r), .warm_reset_r(warm_reset_r), .resume_r(resume_r),
        .irq_ack_r(irq_ack_r), .clock_pin_out_r(clock_pin_out_r));

    // Second build: clock output pin driven and the paired clear instructions.
    wdh_watchdog_halt #(.SYS_DIV(2), .EXT_RC_MODE(1'b1), .DUAL_CLEAR(1'b1)) dut_dual (
        .clk(clk), .nrst(nrst), .bus(bus), .rdata_r(rdata2),
        .wdt_osc_pin(wdt_osc_pin), .rtc_pin(rtc_pin), .external_init_pin_n(ext_n),
        .port_a_pin(port_a_pin), .irq(irq), .sys_tick_r(), .halted_r(),
        .chip_reset_r(), .warm_reset_r(), .resume_r(), .irq_ack_r(),
        .clock_pin_out_r(clk_out2));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rdchk(string nm, logic [3:0] a, logic [7:0] e);
        @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk) bus.rd <= 1'b0;
        #1 chk(nm, {8'h00, e}, {8'h00, rdata_r});
        rd = rdata2;
    endtask

    task automatic ticks(int n);
        repeat (n) begin
            @(posedge clk) wdt_osc_pin <= 1'b1;
            repeat (2) @(posedge clk);
            wdt_osc_pin <= 1'b0;
            @(posedge clk);
        end
    endtask

    // Counts system ticks until the first resume, warm or vector pulse; bounded wait.
    task automatic wait_wake();
        nt = 0;
        kind = 3'h0;
        for (int i = 0; i < 5000 && kind === 3'h0; i++) begin
            @(posedge clk);
            #1;
            if (sys_tick_r === 1'b1) nt++;
            kind = {irq_ack_r, warm_reset_r, resume_r};
        end
    endtask

    task automatic wait_reset_done();
        int i;
        for (i = 0; i < 5000 && chip_reset_r !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        chk("reset_end", 16'h0, (i == 5000) ? 16'h1 : 16'h0);
    endtask

    task automatic final_report();
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_and_select();
        int   ne;
        logic pv;
        rdchk("sel_reset", wdh_pkg::ADDR_SEL, wdh_pkg::SEL_RST);
        rdchk("stat_reset", wdh_pkg::ADDR_STAT, 8'h00);
        rdchk("unmapped", 4'h7, 8'h00);
        chk("clk_out", 16'h0, {15'h0, clock_pin_out_r});
        ne = 0;
        pv = clk_out2;
        repeat (80) begin
            @(posedge clk);
            #1;
            if (clk_out2 === 1'b1 && pv === 1'b0) ne++;
            pv = clk_out2;
        end
        chk("clk_div4", 16'd10, ne[15:0]);
        wr(wdh_pkg::ADDR_SEL, 8'ha8);
        rdchk("sel_store", wdh_pkg::ADDR_SEL, 8'ha8);
    endtask

    task automatic t_port_wake();
        wr(wdh_pkg::ADDR_CMD, 8'h08);
        #1 chk("halted", 16'h1, {15'h0, halted_r});
        rdchk("stat_halt", wdh_pkg::ADDR_STAT, 8'h10);
        @(posedge clk) port_a_pin <= 8'hfe;
        wait_wake();
        chk("port_kind", 16'h1, {13'h0, kind});
        chk("dummy_ticks", 16'd1024, nt[15:0]);
        @(posedge clk) port_a_pin <= 8'hff;
        wr(wdh_pkg::ADDR_CMD, 8'h01);
        rdchk("stat_clr", wdh_pkg::ADDR_STAT, 8'h00);
    endtask

    task automatic t_overflow_run();
        ticks(255);
        chk("no_early", 16'h0, {15'h0, chip_reset_r});
        ticks(1);
        repeat (6) @(posedge clk);
        chk("run_ovf", 16'h1, {15'h0, chip_reset_r});
        wait_reset_done();
        rdchk("stat_to", wdh_pkg::ADDR_STAT, 8'h20);
        rdchk("sel_reload", wdh_pkg::ADDR_SEL, wdh_pkg::SEL_RST);
    endtask

    task automatic t_overflow_halt();
        wr(wdh_pkg::ADDR_SEL, 8'h00);
        wr(wdh_pkg::ADDR_CMD, 8'h08);
        rdchk("stat_halt2", wdh_pkg::ADDR_STAT, 8'h10);
        ticks(256);
        wait_wake();
        chk("warm_kind", 16'h2, {13'h0, kind});
        rdchk("stat_warm", wdh_pkg::ADDR_STAT, 8'h30);
        rdchk("sel_kept", wdh_pkg::ADDR_SEL, 8'h00);
    endtask

    task automatic t_irq_wake();
        @(posedge clk) irq <= '{req: 1'b1, enabled: 1'b1, stack_full: 1'b0};
        wr(wdh_pkg::ADDR_CMD, 8'h08);
        repeat (20) @(posedge clk);
        chk("pending_irq", 16'h1, {15'h0, halted_r});
        port_a_pin <= 8'h7f;
        wait_wake();
        chk("port7_kind", 16'h1, {13'h0, kind});
        @(posedge clk) port_a_pin <= 8'hff;
        irq.req <= 1'b0;
        wr(wdh_pkg::ADDR_CMD, 8'h08);
        @(posedge clk) irq.req <= 1'b1;
        wait_wake();
        chk("irq_kind", 16'h4, {13'h0, kind});
        @(posedge clk) irq <= '{req: 1'b0, enabled: 1'b0, stack_full: 1'b0};
        wr(wdh_pkg::ADDR_CMD, 8'h08);
        @(posedge clk) irq.req <= 1'b1;
        wait_wake();
        chk("irq_resume", 16'h1, {13'h0, kind});
        @(posedge clk) irq.req <= 1'b0;
    endtask

    task automatic t_ext_reset();
        wr(wdh_pkg::ADDR_SEL, 8'h05);
        ticks(10);
        rdchk("cnt_run", wdh_pkg::ADDR_CNT, 8'h0a);
        wr(wdh_pkg::ADDR_CMD, 8'h02);
        rdchk("cnt_first", wdh_pkg::ADDR_CNT, 8'h0a);
        chk("cnt2_first", 16'h0a, {8'h00, rd});
        wr(wdh_pkg::ADDR_CMD, 8'h04);
        rdchk("cnt_second", wdh_pkg::ADDR_CNT, 8'h0a);
        chk("cnt2_pair", 16'h00, {8'h00, rd});
        @(posedge clk) ext_n <= 1'b0;
        repeat (8) @(posedge clk);
        ext_n <= 1'b1;
        wait_reset_done();
        rdchk("sel_ext", wdh_pkg::ADDR_SEL, wdh_pkg::SEL_RST);
        rdchk("cnt_ext", wdh_pkg::ADDR_CNT, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        nrst = 1'b0;
        bus = '0;
        irq = '0;
        port_a_pin = 8'hff;
        wdt_osc_pin = 1'b0;
        rtc_pin = 1'b0;
        ext_n = 1'b1;
        err_count = 0;
        num_checks = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset_and_select();
        t_port_wake();
        t_overflow_run();
        t_overflow_halt();
        t_irq_wake();
        t_ext_reset();
        final_report();
    end

    // The tests take about 16000 cycles; allow roughly three times that.
    initial begin
        #250000;
        err_count++;
        final_report();
    end
endmodule
